// ==== sim/gpio7_pin_control_tb_top.sv ====
`timescale 1ns/10ps
module gpio7_pin_control_tb_top;
   import gps_pkg::*;
   localparam int SDB = 2;
   localparam int LDB = 12;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [15:0] i_addr = 16'h0;
   logic [15:0] i_wdata = 16'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic drv_en = 1'b1; // partner drives pin
   logic drv_val = 1'b0;
   logic [15:0] s = 16'h0; // source per output code
   logic [15:0] o_rdata;
   logic o_pin_out, o_pin_oe, o_pull_up, o_pull_down, o_sup, o_pin_irq, pin_w;
   logic [10:0] sk; // all sink outputs
   logic [15:0] expq[$];
   logic rd_pend = 1'b0;
   logic [15:0] r;
   logic [15:0] icfg[3] = '{16'h8481, 16'h8081, 16'h9481};
   logic [1:0] iexp[3] = '{2'b10, 2'b01, 2'b11}; // irq on rise, on fall
   int n_fail = 0;
   int n_compared = 0;
   int n_irq = 0;
   int n_cyc = 0;
   int n;
   int k;
   always #2 i_clk = ~i_clk;
   gps_pin_ctrl #(.SHORT_DB_CYC(SDB), .LONG_DB_CYC(LDB)) u_dut (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin_in(pin_w),
      .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_pull_up(o_pull_up),
      .o_pull_down(o_pull_down), .o_supply_always_on(o_sup), .o_pin_irq(o_pin_irq),
      .i_osc_32k(s[1]), .i_on_state(s[2]), .i_sleep_state(s[3]),
      .i_state_change(s[4]), .i_vs_done(s[9:8]), .i_ext_pwr_en(s[11:10]),
      .i_system_supply_good(s[12]), .i_converter_power_good(s[13]),
      .i_aux_reset(s[15]), .o_power_onoff_req(sk[0]), .o_sleep_wake_req(sk[1]),
      .o_sleep_req(sk[2]), .o_power_on_req(sk[3]), .o_watchdog_reset(sk[4]),
      .o_voltage_scale_select_one(sk[5]), .o_voltage_scale_select_two(sk[6]),
      .o_hw_enable(sk[8:7]), .o_hw_control(sk[10:9]));
   gps_pin_partner u_far (.i_clk(i_clk), .i_drive_en(drv_en), .i_drive_val(drv_val),
      .i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_pull_up(o_pull_up),
      .i_pull_down(o_pull_down), .o_wire(pin_w));
   // expected sink bit for an input code
   function automatic logic [10:0] sink_of(input int c);
      case (c)
         2: return 11'h001;
         3, 4: return 11'h002;
         5: return 11'h004;
         6: return 11'h008;
         7: return 11'h010;
         8: return 11'h020;
         9: return 11'h040;
         10: return 11'h080;
         11: return 11'h100;
         12, 14: return 11'h200;
         13, 15: return 11'h400;
         default: return 11'h000;
      endcase
   endfunction : sink_of
   task automatic cyc(input int c);
      repeat (c) @(posedge i_clk);
   endtask : cyc
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
      @(posedge i_clk);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      expq.push_back(e);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      @(posedge i_clk);
   endtask : rd
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic summarize;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   // code 0 output case: pin value and enable
   task automatic ocase(input logic [15:0] c, input logic l, input logic [1:0] e);
      wr(GPS_LVL_OFS, {15'h0, l});
      wr(GPS_CTRL_OFS, c);
      cyc(3);
      chk("out oe", {14'h0, e}, {14'h0, o_pin_out & o_pin_oe, o_pin_oe});
   endtask : ocase
   // read data watcher, irq counter and timeout
   always @(posedge i_clk) begin
      if (rd_pend) chk("rdata", expq.pop_front(), o_rdata);
      else if (o_rdata !== 16'h0) chk("rdata idle", 16'h0, o_rdata);
      rd_pend <= i_rd;
      if (o_pin_irq === 1'b1) n_irq++;
      n_cyc++;
      if (n_cyc == 30000) begin
         n_fail++;
         summarize();
      end
   end
   initial begin
      k = $urandom(5699);
      cyc(3);
      i_arst_n <= 1'b1;
      @(posedge i_clk);
      chk("pulls", 16'h1, {14'h0, o_pull_up, o_pull_down});
      chk("sup oe", 16'h0, {14'h0, o_sup, o_pin_oe});
      rd(GPS_CTRL_OFS, GPS_CTRL_RST);
      for (k = 0; k < 4; k++) begin
         r = 16'($urandom);
         wr(GPS_CTRL_OFS, r);
         rd(GPS_CTRL_OFS, r & GPS_CTRL_WMASK);
      end
      wr(16'h1234, 16'hffff);
      rd(16'h1234, 16'h0);
      rd(GPS_CTRL_OFS, r & GPS_CTRL_WMASK);
      for (k = 0; k < 4; k++) begin
         wr(GPS_CTRL_OFS, 16'(k << 13) | 16'h0800);
         cyc(2);
         chk("pulls", {14'h0, k == 2, k == 1}, {14'h0, o_pull_up, o_pull_down});
         chk("supply", 16'h1, {15'h0, o_sup});
      end
      drv_en <= 1'b0;
      wr(GPS_LVL_OFS, 16'h0001);
      for (k = 0; k < 16; k++) begin
         s <= 16'($urandom) & 16'hbf1e;
         wr(GPS_CTRL_OFS, 16'h0480 | 16'(k));
         cyc(3);
         if (k == 14) begin
            n = 0;
            repeat (GPS_EXT_DIV) begin
               @(posedge i_clk);
               n += int'(o_pin_out === 1'b1);
            end
            chk("ext clk highs", 16'(GPS_EXT_HALF), 16'(n));
         end else chk("pin out", {15'h0, (k == 0) | s[k]}, {15'h0, o_pin_out});
         chk("pin oe", 16'h1, {15'h0, o_pin_oe});
      end
      ocase(16'h0080, 1'b1, 2'b01);
      ocase(16'h0680, 1'b1, 2'b00);
      ocase(16'h0680, 1'b0, 2'b01);
      ocase(16'h0400, 1'b0, 2'b00);
      drv_en <= 1'b1;
      for (k = 0; k < 16; k++) begin
         wr(GPS_CTRL_OFS, 16'h8480 | 16'(k));
         // settle both filters low first, the floating pin may leave them high
         cyc(LDB + 6);
         drv_val <= 1'b1;
         cyc(SDB + 4);
         if (k < 2) rd(GPS_LVL_OFS, {14'h0, k == 1, 1'b0});
         cyc(LDB + 6);
         chk("sinks", {5'h0, sink_of(k)}, {5'h0, sk});
         chk("input oe", 16'h0, {15'h0, o_pin_oe});
         drv_val <= 1'b0;
         cyc(LDB + 6);
         chk("sinks low", 16'h0, {5'h0, sk});
      end
      for (k = 0; k < 3; k++) begin
         wr(GPS_CTRL_OFS, icfg[k]);
         cyc(LDB + 6);
         n_irq = 0;
         drv_val <= 1'b1;
         cyc(LDB + 6);
         chk("irq rise", 16'(iexp[k][1]), 16'(n_irq));
         drv_val <= 1'b0;
         cyc(LDB + 6);
         chk("irq fall", 16'(iexp[k][1]) + 16'(iexp[k][0]), 16'(n_irq));
      end
      summarize();
   end
endmodule : gpio7_pin_control_tb_top

// ==== sim/gps_pin_partner.sv ====
`timescale 1ns/10ps
// ****************************************************
// far side of the pin: external logic and pad wire
// ****************************************************
module gps_pin_partner (
   input wire logic i_clk,
   input wire logic i_drive_en,
   input wire logic i_drive_val,
   input wire logic i_pin_out,
   input wire logic i_pin_oe,
   input wire logic i_pull_up,
   input wire logic i_pull_down,
   output logic o_wire
);
   logic last_q = 1'b0; // last resolved wire level
   // remember level so a floating wire can toggle
   always_ff @(posedge i_clk) begin
      last_q <= o_wire;
   end
   // wire level from all enables; floating wire shows the inverse
   assign o_wire = i_pin_oe ? i_pin_out : i_drive_en ? i_drive_val :
      i_pull_up ? 1'b1 : i_pull_down ? 1'b0 : ~last_q;
endmodule : gps_pin_partner

// ==== verilog/gps_dbc_if.sv ====
`timescale 1ns/10ps
// ****************************************************
// raw level in, filtered level out of one debouncer
// ****************************************************
interface gps_dbc_if;
   logic raw;    // active-level sample of the pin
   logic clean;  // level after the filter
   modport filt (input raw, output clean);
   modport user (output raw, input clean);
endinterface : gps_dbc_if

// ==== verilog/gps_debounce.sv ====
`timescale 1ns/10ps
// ****************************************************
// stable-count debouncer
// ****************************************************
module gps_debounce import gps_pkg::*; #(
   parameter int CYC = GPS_SHORT_DB_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   gps_dbc_if.filt bus
);
   localparam int CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   logic [CW-1:0] cnt_q;  // cycles the raw level has differed
   logic clean_q;         // filtered level
   wire differ = bus.raw != clean_q;
   wire done = cnt_q == LAST;

   // count a new level, accept it once stable for CYC cycles
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= '0;
         clean_q <= 1'b0;
      end else if (!differ) begin
         cnt_q <= '0;
      end else if (done) begin
         cnt_q <= '0;
         clean_q <= bus.raw;
      end else begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   assign bus.clean = clean_q;
endmodule : gps_debounce

// ==== verilog/gps_pin_ctrl.sv ====
`timescale 1ns/10ps
// Behaviour
// - pull field: none, down, up, reserved
// - mode 0: one edge chosen by polarity
// - mode 1: interrupt on both edges
// - bit 11 picks pin supply domain
// - polarity bit sets pin sense
// - bit 9 picks push-pull or open-drain
// - enable low keeps pin tri-stated
// - input codes 0,1: plain input, debounce
// - input codes 2-6: power requests
// - input codes 7-9: watchdog, voltage selects
// - input codes 10-15: hardware enables, controls
// - output codes 0-4: register, osc, states
// - output 12-15: good flags, clock, reset
module gps_pin_ctrl import gps_pkg::*; #(
   parameter int SHORT_DB_CYC = GPS_SHORT_DB_CYC,
   parameter int LONG_DB_CYC = GPS_LONG_DB_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   // register port
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // pin
   input wire logic i_pin_in,
   output logic o_pin_out,
   output logic o_pin_oe,
   output logic o_pull_up,
   output logic o_pull_down,
   output logic o_supply_always_on,
   output logic o_pin_irq,
   // internal sources for output functions
   input wire logic i_osc_32k,
   input wire logic i_on_state,
   input wire logic i_sleep_state,
   input wire logic i_state_change,
   input wire logic [1:0] i_vs_done,
   input wire logic [1:0] i_ext_pwr_en,
   input wire logic i_system_supply_good,
   input wire logic i_converter_power_good,
   input wire logic i_aux_reset,
   // internal sinks for input functions
   output logic o_power_onoff_req,
   output logic o_sleep_wake_req,
   output logic o_sleep_req,
   output logic o_power_on_req,
   output logic o_watchdog_reset,
   output logic o_voltage_scale_select_one,
   output logic o_voltage_scale_select_two,
   output logic [1:0] o_hw_enable,
   output logic [1:0] o_hw_control
);
   // ****************************************************
   // register port
   // ****************************************************
   logic [15:0] ctrl_q;   // pin_seven_control
   logic out_lvl_q;       // value for register-driven output
   logic [15:0] rdata_q;  // read data, valid one cycle after strobe

   wire hit_ctrl = i_addr == GPS_CTRL_OFS;
   wire hit_lvl = i_addr == GPS_LVL_OFS;
   wire wr_ctrl = i_wr && hit_ctrl;
   wire wr_lvl = i_wr && hit_lvl;

   // control fields
   wire dir_in = ctrl_q[GPS_DIR_BIT];
   wire [1:0] pull = ctrl_q[GPS_PULL_HI:GPS_PULL_LO];
   wire both_edges = ctrl_q[GPS_IMODE_BIT];
   wire pol_high = ctrl_q[GPS_POL_BIT];
   wire od_mode = ctrl_q[GPS_OD_BIT];
   wire pin_en = ctrl_q[GPS_ENA_BIT];
   wire [3:0] fn = ctrl_q[GPS_FN_HI:0];

   // write path, unassigned bits masked off
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_q <= GPS_CTRL_RST;
         out_lvl_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= i_wdata & GPS_CTRL_WMASK;
         end
         if (wr_lvl) begin
            out_lvl_q <= i_wdata[GPS_LVL_OUT_BIT];
         end
      end
   end

   // read mux, unmapped addresses read zero
   logic sel_lvl;  // filtered input level in use
   wire [15:0] lvl_word = {14'h0000, sel_lvl, out_lvl_q};
   wire [15:0] rd_mux = hit_ctrl ? ctrl_q : (hit_lvl ? lvl_word : 16'h0000);

   // read data stands only in the cycle after the strobe
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= i_rd ? rd_mux : 16'h0000;
      end
   end
   assign o_rdata = rdata_q;

   // ****************************************************
   // static pad settings
   // ****************************************************
   // pull decode, reserved code pulls nothing
   assign o_pull_down = pull == GPS_PULL_DOWN;
   assign o_pull_up = pull == GPS_PULL_UP;
   assign o_supply_always_on = ctrl_q[GPS_SUP_BIT];

   // ****************************************************
   // input path and debounce
   // ****************************************************
   logic pin_q;  // pin sample
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= i_pin_in;
      end
   end

   // active level, inverted when polarity is low
   wire act_raw = pin_q ^ ~pol_high;

   gps_dbc_if db_short ();
   gps_dbc_if db_long ();
   assign db_short.raw = act_raw;
   assign db_long.raw = act_raw;

   gps_debounce #(.CYC(SHORT_DB_CYC)) u_db_short (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .bus(db_short.filt)
   );
   gps_debounce #(.CYC(LONG_DB_CYC)) u_db_long (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .bus(db_long.filt)
   );

   wire lvl_s = db_short.clean;
   wire lvl_l = db_long.clean;
   // long filter for codes marked long
   wire use_long = fn == GPS_FN_GPIO_LONG || fn == GPS_FN_SLWK_LONG
                   || fn == GPS_FN_HWC1_LONG || fn == GPS_FN_HWC2_LONG;
   assign sel_lvl = use_long ? lvl_l : lvl_s;
   wire in_act = pin_en && dir_in;

   // ****************************************************
   // input function routing
   // ****************************************************
   // request, watchdog, voltage select and hardware decode
   wire onoff_d = in_act && fn == GPS_FN_ONOFF && lvl_s;
   wire slwk_d = in_act && ((fn == GPS_FN_SLWK && lvl_s)
                 || (fn == GPS_FN_SLWK_LONG && lvl_l));
   wire sleep_d = in_act && fn == GPS_FN_SLEEP && lvl_s;
   wire pwron_d = in_act && fn == GPS_FN_PWRON && lvl_s;
   wire wdog_d = in_act && fn == GPS_FN_WDOG && lvl_s;
   wire vs1_d = in_act && fn == GPS_FN_VS1 && lvl_s;
   wire vs2_d = in_act && fn == GPS_FN_VS2 && lvl_s;
   wire [1:0] hwen_d = {in_act && fn == GPS_FN_HWEN2 && lvl_s,
                        in_act && fn == GPS_FN_HWEN1 && lvl_s};
   wire hwc1_d = (fn == GPS_FN_HWC1 && lvl_s) || (fn == GPS_FN_HWC1_LONG && lvl_l);
   wire hwc2_d = (fn == GPS_FN_HWC2 && lvl_s) || (fn == GPS_FN_HWC2_LONG && lvl_l);
   wire [1:0] hwc_d = {in_act && hwc2_d, in_act && hwc1_d};

   // registered sinks
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_power_onoff_req <= 1'b0;
         o_sleep_wake_req <= 1'b0;
         o_sleep_req <= 1'b0;
         o_power_on_req <= 1'b0;
         o_watchdog_reset <= 1'b0;
         o_voltage_scale_select_one <= 1'b0;
         o_voltage_scale_select_two <= 1'b0;
         o_hw_enable <= 2'h0;
         o_hw_control <= 2'h0;
      end else begin
         o_power_onoff_req <= onoff_d;
         o_sleep_wake_req <= slwk_d;
         o_sleep_req <= sleep_d;
         o_power_on_req <= pwron_d;
         o_watchdog_reset <= wdog_d;
         o_voltage_scale_select_one <= vs1_d;
         o_voltage_scale_select_two <= vs2_d;
         o_hw_enable <= hwen_d;
         o_hw_control <= hwc_d;
      end
   end

   // ****************************************************
   // edge interrupt
   // ****************************************************
   logic prev_lvl_q;  // level one cycle ago
   logic irq_q;       // one-cycle interrupt pulse
   wire rose = sel_lvl && !prev_lvl_q;
   wire fell = !sel_lvl && prev_lvl_q;
   // single edge: active-going, pin edge set by polarity
   wire edge_hit = in_act && (rose || (both_edges && fell));

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         prev_lvl_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         prev_lvl_q <= sel_lvl;
         irq_q <= edge_hit;
      end
   end
   assign o_pin_irq = irq_q;

   // ****************************************************
   // external power clock divider
   // ****************************************************
   logic [7:0] ext_cnt_q;  // position within one 2 MHz period
   wire ext_wrap = ext_cnt_q == 8'(GPS_EXT_DIV - 1);
   wire ext_clk = ext_cnt_q < 8'(GPS_EXT_HALF);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ext_cnt_q <= 8'h00;
      end else begin
         ext_cnt_q <= ext_wrap ? 8'h00 : ext_cnt_q + 8'h01;
      end
   end

   // ****************************************************
   // output function routing
   // ****************************************************
   logic [15:0] out_src;  // source per function code
   assign out_src[0] = out_lvl_q;
   assign out_src[1] = i_osc_32k;
   assign out_src[2] = i_on_state;
   assign out_src[3] = i_sleep_state;
   assign out_src[4] = i_state_change;
   // reserved codes idle, then done and enables
   assign out_src[7:5] = 3'h0;
   assign out_src[9:8] = i_vs_done;
   assign out_src[11:10] = i_ext_pwr_en;
   // good flags, 2 MHz clock, auxiliary reset
   assign out_src[12] = i_system_supply_good;
   assign out_src[13] = i_converter_power_good;
   assign out_src[14] = ext_clk;
   assign out_src[15] = i_aux_reset;

   // active-low sense inverts the pin level
   wire pin_val = out_src[fn] ^ ~pol_high;
   // disabled or input pin never driven
   wire oe_d = pin_en && !dir_in && (!od_mode || !pin_val);
   wire out_d = od_mode ? 1'b0 : pin_val;

   logic pin_out_q;  // registered pin level
   logic pin_oe_q;   // registered drive enable
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_out_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_out_q <= out_d;
         pin_oe_q <= oe_d;
      end
   end
   assign o_pin_out = pin_out_q;
   assign o_pin_oe = pin_oe_q;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sequence s_ctrl_write;
      wr_ctrl;
   endsequence

   a_rsv_bits_zero: assert property (
      s_ctrl_write |=> ctrl_q[8] == 1'b0 && ctrl_q[6:4] == 3'h0)
      else $error("unassigned control bits not zero");

   a_pull_decode: assert property (
      s_ctrl_write |=> (o_pull_down == ($past(i_wdata[14:13]) == 2'h1))
         && (o_pull_up == ($past(i_wdata[14:13]) == 2'h2)))
      else $error("pull outputs disagree with written field");

   a_supply_sel: assert property (
      s_ctrl_write |=> o_supply_always_on == $past(i_wdata[11]))
      else $error("supply select not taken from write");

   a_edge_single: assert property (
      in_act && !both_edges && fell |=> !o_pin_irq)
      else $error("interrupt on wrong edge in single mode");

   a_edge_both: assert property (
      in_act && both_edges && fell |=> o_pin_irq)
      else $error("missing interrupt in both-edge mode");

   a_edge_rise: assert property (
      in_act && rose |=> o_pin_irq)
      else $error("missing interrupt on active edge");

   a_tristate_off: assert property (
      !pin_en || dir_in |=> !o_pin_oe)
      else $error("pin driven while disabled or input");

   a_od_no_high: assert property (
      od_mode && $stable(ctrl_q) |=> !o_pin_oe || !o_pin_out)
      else $error("open drain drove high");

   a_pol_output: assert property (
      !dir_in && pin_en && !od_mode && fn == 4'h0
         |=> o_pin_out == ($past(out_lvl_q) ^ ~$past(pol_high)) && o_pin_oe)
      else $error("register-driven output level wrong");

   a_in_request: assert property (
      in_act && fn == 4'h2 |=> o_power_onoff_req == $past(lvl_s))
      else $error("power request not following level");

   a_wdog_input: assert property (
      in_act && fn == 4'h7 |=> o_watchdog_reset == $past(lvl_s) && !o_sleep_req)
      else $error("watchdog input routed wrongly");

   a_hw_long: assert property (
      in_act && fn == 4'he |=> o_hw_control[0] == $past(lvl_l) && !o_hw_control[1])
      else $error("long-debounced control routed wrongly");
endmodule : gps_pin_ctrl

// ==== verilog/gps_pkg.sv ====
// ****************************************************
// shared constants for the pin seven control block
// ****************************************************
package gps_pkg;
   // register offsets (word addresses on the plain port)
   localparam logic [15:0] GPS_CTRL_OFS = 16'h403e;  // pin_seven_control
   localparam logic [15:0] GPS_LVL_OFS = 16'h4100;   // pin level register
   // control register reset value and writable bits
   localparam logic [15:0] GPS_CTRL_RST = 16'ha400;
   localparam logic [15:0] GPS_CTRL_WMASK = 16'hfe8f;
   // field positions
   localparam int GPS_DIR_BIT = 15;    // pin_direction_sel, 1 = input
   localparam int GPS_PULL_HI = 14;    // pin_resistor_sel msb
   localparam int GPS_PULL_LO = 13;    // pin_resistor_sel lsb
   localparam int GPS_IMODE_BIT = 12;  // edge_irq_select
   localparam int GPS_SUP_BIT = 11;    // pin_supply_select
   localparam int GPS_POL_BIT = 10;    // pin_sense_invert, 1 = active high
   localparam int GPS_OD_BIT = 9;      // drain_only_driver
   localparam int GPS_ENA_BIT = 7;     // pin_drive_enable
   localparam int GPS_FN_HI = 3;       // pin_function_code msb
   // pull field codes
   localparam logic [1:0] GPS_PULL_DOWN = 2'h1;
   localparam logic [1:0] GPS_PULL_UP = 2'h2;
   // level register bits
   localparam int GPS_LVL_OUT_BIT = 0;  // value for register-driven output
   localparam int GPS_LVL_IN_BIT = 1;   // filtered input level (read only)
   // function codes that carry special meaning
   localparam logic [3:0] GPS_FN_GPIO_LONG = 4'h0;
   localparam logic [3:0] GPS_FN_GPIO = 4'h1;
   localparam logic [3:0] GPS_FN_ONOFF = 4'h2;
   localparam logic [3:0] GPS_FN_SLWK = 4'h3;
   localparam logic [3:0] GPS_FN_SLWK_LONG = 4'h4;
   localparam logic [3:0] GPS_FN_SLEEP = 4'h5;
   localparam logic [3:0] GPS_FN_PWRON = 4'h6;
   localparam logic [3:0] GPS_FN_WDOG = 4'h7;
   localparam logic [3:0] GPS_FN_VS1 = 4'h8;
   localparam logic [3:0] GPS_FN_VS2 = 4'h9;
   localparam logic [3:0] GPS_FN_HWEN1 = 4'ha;
   localparam logic [3:0] GPS_FN_HWEN2 = 4'hb;
   localparam logic [3:0] GPS_FN_HWC1 = 4'hc;
   localparam logic [3:0] GPS_FN_HWC2 = 4'hd;
   localparam logic [3:0] GPS_FN_HWC1_LONG = 4'he;
   localparam logic [3:0] GPS_FN_HWC2_LONG = 4'hf;
   // clock and external power clock timing
   localparam longint GPS_CLK_HZ = 250000000;
   localparam longint GPS_EXT_CLK_HZ = 2000000;
   localparam int GPS_EXT_DIV = int'(GPS_CLK_HZ / GPS_EXT_CLK_HZ);
   localparam int GPS_EXT_HALF = GPS_EXT_DIV / 2;
   // default debounce lengths in clock cycles
   localparam int GPS_SHORT_DB_CYC = 16;
   localparam int GPS_LONG_DB_CYC = 1024;
endpackage : gps_pkg
